// >>> core/phc_pkg.sv
// phy port control/status register bank: shared constants
// assumes 16-bit registers on a 32-bit apb bus, byte address = index * 4
package phc_pkg;

	// ------------------------------------------------------------
	// bank numbers and register indices
	// ------------------------------------------------------------
	localparam logic [7:0]  PHC_BANK_CABLE     = 8'h2F;
	localparam logic [7:0]  PHC_BANK_PORT      = 8'h31;
	localparam logic [3:0]  PHC_IDX_CABLE      = 4'h0;
	localparam logic [3:0]  PHC_IDX_SPECIAL    = 4'h2;
	localparam logic [3:0]  PHC_IDX_COMBINED   = 4'h0;
	localparam logic [3:0]  PHC_IDX_PORT_CTRL  = 4'h2;
	localparam logic [3:0]  PHC_IDX_PORT_STAT  = 4'h4;
	localparam logic [3:0]  PHC_IDX_BANK_SEL   = 4'hE;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PHC_SP_POLARITY  = 5;
	localparam int PHC_SP_XOVER     = 4;
	localparam int PHC_SP_CTRL_LO   = 1;
	localparam int PHC_CB_SHORT     = 15;
	localparam int PHC_CB_RES_LO    = 13;
	localparam int PHC_CB_GO        = 12;
	localparam int PHC_CB_CTRL_LO   = 9;
	localparam int PHC_CT_GO        = 15;
	localparam int PHC_PC_LED_OFF   = 15;
	localparam int PHC_PC_TX_DIS    = 14;
	localparam int PHC_PC_AN_RST    = 13;
	localparam int PHC_PC_PWR_DOWN  = 11;
	localparam int PHC_PC_MDIX_DIS  = 10;
	localparam int PHC_PC_FORCE_MDX = 9;
	localparam int PHC_PC_AN_EN     = 7;
	localparam int PHC_PC_SPEED     = 6;
	localparam int PHC_PC_DUPLEX    = 5;
	localparam int PHC_ST_POLARITY  = 13;
	localparam int PHC_ST_RX_FC     = 12;
	localparam int PHC_ST_TX_FC     = 11;
	localparam int PHC_ST_SPEED     = 10;
	localparam int PHC_ST_DUPLEX    = 9;
	localparam int PHC_ST_XOVER     = 7;
	localparam int PHC_ST_AN_DONE   = 6;
	localparam int PHC_ST_LINK      = 5;

	// ------------------------------------------------------------
	// reset values and write masks
	// ------------------------------------------------------------
	localparam logic [2:0]  PHC_PHY_CTRL_RST   = 3'h2;
	localparam logic [15:0] PHC_PORT_CTRL_RST  = 16'h009F;
	localparam logic [15:0] PHC_PORT_CTRL_WMSK = 16'hEEFF;
	localparam logic [7:0]  PHC_BANK_SEL_RST   = 8'h00;

	// ------------------------------------------------------------
	// cable test sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PHC_CT_IDLE    = 2'b00,
		PHC_CT_RUN     = 2'b01,
		PHC_CT_RELEASE = 2'b10
	} phc_ct_state_e;

endpackage : phc_pkg

// >>> core/phc_cable_if.sv
// carrier between register bank and cable test sequencer
// assumes both ends share clk_i
`timescale 1ns/100ps
interface phc_cable_if;
	logic go;
	logic done;
	logic run;
	logic finish;
	modport regs   (output go, output done, input run, input finish);
	modport engine (input go, input done, output run, output finish);
endinterface : phc_cable_if

// >>> core/phc_sync.sv
// two-stage level synchroniser for a vector of pin inputs
// assumes each bit is a quasi-static level from outside the clock domain
`timescale 1ns/100ps
module phc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	// data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule : phc_sync

// >>> core/phc_cable_seq.sv
// cable diagnostic sequencer: runs the tester, reports finish
// assumes done from the tester is already synchronised and rises only while run is high
`timescale 1ns/100ps
module phc_cable_seq
	import phc_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// register side
	phc_cable_if.engine cif
);
	phc_ct_state_e state;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state      <= PHC_CT_IDLE;
			cif.finish <= 1'b0;
		end else begin
			cif.finish <= 1'b0;
			case (state)
				PHC_CT_IDLE: begin
					if (cif.go && !cif.done) begin
						state <= PHC_CT_RUN;
					end
				end
				PHC_CT_RUN: begin
					if (cif.done) begin
						cif.finish <= 1'b1;
						state      <= PHC_CT_RELEASE;
					end
				end
				PHC_CT_RELEASE: begin
					if (!cif.done) begin
						state <= PHC_CT_IDLE;
					end
				end
				default: begin
					state <= PHC_CT_IDLE;
				end
			endcase
		end
	end

	assign cif.run = (state == PHC_CT_RUN);
endmodule : phc_cable_seq

// >>> core/phc_regs.sv
// phy port control/status register bank, apb slave
// assumes phy status and tester inputs are asynchronous levels; led_i is on clk_i
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module phc_regs
	import phc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// phy status, asynchronous
	input  wire logic        polarity_reversed_i,
	input  wire logic        crossover_state_i,
	input  wire logic        link_good_i,
	input  wire logic        an_done_i,
	input  wire logic        an_failed_i,
	input  wire logic        op_speed_100_i,
	input  wire logic        op_duplex_full_i,
	input  wire logic [4:0]  partner_ability_i,
	input  wire logic        rx_flow_ctrl_i,
	input  wire logic        tx_flow_ctrl_i,
	// cable tester, asynchronous
	input  wire logic        cable_done_i,
	input  wire logic [1:0]  cable_result_i,
	input  wire logic        short_within_ten_metres_i,
	input  wire logic [8:0]  cable_fault_count_i,
	output logic             cable_test_run_o,
	// phy controls
	output logic             force_link_o,
	output logic             power_save_dis_o,
	output logic             near_loopback_o,
	output logic             tx_disable_o,
	output logic             an_restart_o,
	output logic             power_down_o,
	output logic             auto_mdix_dis_o,
	output logic             force_mdix_o,
	output logic             an_enable_o,
	output logic             force_speed_100_o,
	output logic             force_duplex_full_o,
	output logic             force_duplex_apply_o,
	output logic      [4:0]  advertise_o,
	// leds
	input  wire logic [3:0]  led_i,
	output logic      [3:0]  port_led_out_o
);
	localparam int SW = 27;

	// ------------------------------------------------------------
	// synchronised inputs
	// ------------------------------------------------------------
	logic [SW-1:0] sync_in;
	logic [SW-1:0] sync_out;
	logic          s_polarity;
	logic          s_xover;
	logic          s_link;
	logic          s_an_done;
	logic          s_an_failed;
	logic          s_speed;
	logic          s_duplex;
	logic [4:0]    s_partner;
	logic          s_rx_fc;
	logic          s_tx_fc;
	logic          s_done;
	logic [1:0]    s_result;
	logic          s_short;
	logic [8:0]    s_count;

	assign sync_in = {polarity_reversed_i, crossover_state_i, link_good_i, an_done_i,
		an_failed_i, op_speed_100_i, op_duplex_full_i, partner_ability_i,
		rx_flow_ctrl_i, tx_flow_ctrl_i, cable_done_i, cable_result_i,
		short_within_ten_metres_i, cable_fault_count_i};

	phc_sync #(
		.WIDTH (SW)
	) u_sync (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.async_i (sync_in),
		.sync_o  (sync_out)
	);

	assign {s_polarity, s_xover, s_link, s_an_done, s_an_failed, s_speed, s_duplex,
		s_partner, s_rx_fc, s_tx_fc, s_done, s_result, s_short, s_count} = sync_out;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	logic        wr_en;
	logic        rd_setup;
	logic [7:0]  bank_sel;
	logic [3:0]  idx;
	logic        at_word;
	logic        hit_bank_sel;
	logic        hit_special;
	logic        hit_cable;
	logic        hit_combined;
	logic        hit_port_ctrl;
	logic        hit_port_stat;
	logic        lane0;
	logic        lane1;
	logic [15:0] wd;

	assign wr_en    = psel_i && penable_i && pwrite_i;
	assign rd_setup = psel_i && !penable_i && !pwrite_i;
	assign idx      = paddr_i[5:2];
	assign at_word  = (paddr_i[7:6] == 2'b00) && (paddr_i[1:0] == 2'b00);
	assign lane0    = pstrb_i[0];
	assign lane1    = pstrb_i[1];
	assign wd       = pwdata_i[15:0];

	always_comb begin
		hit_bank_sel  = 1'b0;
		hit_special   = 1'b0;
		hit_cable     = 1'b0;
		hit_combined  = 1'b0;
		hit_port_ctrl = 1'b0;
		hit_port_stat = 1'b0;
		if (!at_word) begin
			hit_bank_sel = 1'b0;
		end else if (idx == PHC_IDX_BANK_SEL) begin
			hit_bank_sel = 1'b1;
		end else if (bank_sel == PHC_BANK_CABLE && idx == PHC_IDX_SPECIAL) begin
			hit_special = 1'b1;
		end else if (bank_sel == PHC_BANK_CABLE && idx == PHC_IDX_CABLE) begin
			hit_cable = 1'b1;
		end else if (bank_sel == PHC_BANK_PORT && idx == PHC_IDX_COMBINED) begin
			hit_combined = 1'b1;
		end else if (bank_sel == PHC_BANK_PORT && idx == PHC_IDX_PORT_CTRL) begin
			hit_port_ctrl = 1'b1;
		end else if (bank_sel == PHC_BANK_PORT && idx == PHC_IDX_PORT_STAT) begin
			hit_port_stat = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// bank select
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bank_sel <= PHC_BANK_SEL_RST;
		end else if (wr_en && hit_bank_sel && lane0) begin
			bank_sel <= wd[7:0];
		end
	end

	// ------------------------------------------------------------
	// shared phy special controls: link, power saving, loopback
	// ------------------------------------------------------------
	logic [2:0] phy_ctrl;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phy_ctrl <= PHC_PHY_CTRL_RST;
		end else if (wr_en && hit_special && lane0) begin
			phy_ctrl <= wd[PHC_SP_CTRL_LO +: 3];
		end else if (wr_en && hit_combined && lane1) begin
			phy_ctrl <= wd[PHC_CB_CTRL_LO +: 3];
		end
	end

	assign force_link_o     = phy_ctrl[2];
	assign power_save_dis_o = phy_ctrl[1];
	assign near_loopback_o  = phy_ctrl[0];

	// ------------------------------------------------------------
	// cable diagnostic start bit and results
	// ------------------------------------------------------------
	phc_cable_if cif ();
	logic        cable_go;
	logic        go_set;
	logic [1:0]  cable_result;
	logic        cable_short;
	logic [8:0]  cable_count;

	assign go_set = wr_en && lane1 &&
		((hit_combined && wd[PHC_CB_GO]) || (hit_cable && wd[PHC_CT_GO]));

	// a new start wins over the finish of the previous test
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cable_go <= 1'b0;
		end else if (go_set) begin
			cable_go <= 1'b1;
		end else if (cif.finish) begin
			cable_go <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cable_result <= 2'b00;
			cable_short  <= 1'b0;
			cable_count  <= 9'h000;
		end else if (cif.finish) begin
			cable_result <= s_result;
			cable_short  <= s_short;
			cable_count  <= s_count;
		end
	end

	assign cif.go  = cable_go;
	assign cif.done = s_done;
	assign cable_test_run_o = cif.run;

	phc_cable_seq u_cable_seq (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.cif    (cif.engine)
	);

	// ------------------------------------------------------------
	// port link control
	// ------------------------------------------------------------
	logic [15:0] port_ctrl;
	logic [15:0] pc_mask;

	assign pc_mask = PHC_PORT_CTRL_WMSK & {{8{lane1}}, {8{lane0}}};

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_ctrl <= PHC_PORT_CTRL_RST;
		end else if (wr_en && hit_port_ctrl) begin
			port_ctrl <= (port_ctrl & ~pc_mask) | (wd & pc_mask);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			an_restart_o <= 1'b0;
		end else begin
			an_restart_o <= wr_en && hit_port_ctrl && lane1 && wd[PHC_PC_AN_RST];
		end
	end

	assign tx_disable_o    = port_ctrl[PHC_PC_TX_DIS];
	assign power_down_o    = port_ctrl[PHC_PC_PWR_DOWN];
	assign auto_mdix_dis_o = port_ctrl[PHC_PC_MDIX_DIS];
	assign an_enable_o     = port_ctrl[PHC_PC_AN_EN];
	assign advertise_o     = port_ctrl[4:0];
	assign force_duplex_full_o = port_ctrl[PHC_PC_DUPLEX];

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			force_mdix_o         <= 1'b0;
			force_speed_100_o    <= 1'b0;
			force_duplex_apply_o <= 1'b0;
		end else begin
			force_mdix_o <= port_ctrl[PHC_PC_MDIX_DIS] && port_ctrl[PHC_PC_FORCE_MDX];
			force_speed_100_o <= !port_ctrl[PHC_PC_AN_EN] && port_ctrl[PHC_PC_SPEED];
			force_duplex_apply_o <= !port_ctrl[PHC_PC_AN_EN] || s_an_failed;
		end
	end

	// ------------------------------------------------------------
	// leds
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			port_led_out_o <= 4'hF;
		end else if (port_ctrl[PHC_PC_LED_OFF]) begin
			port_led_out_o <= 4'hF;
		end else begin
			port_led_out_o <= led_i;
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [15:0] rd_val;

	always_comb begin
		rd_val = 16'h0000;
		if (hit_bank_sel) begin
			rd_val[7:0] = bank_sel;
		end else if (hit_special) begin
			rd_val[PHC_SP_POLARITY]      = s_polarity;
			rd_val[PHC_SP_XOVER]         = s_xover;
			rd_val[PHC_SP_CTRL_LO +: 3]  = phy_ctrl;
		end else if (hit_cable) begin
			rd_val[PHC_CT_GO]            = cable_go;
			rd_val[PHC_CB_RES_LO +: 2]   = cable_result;
			rd_val[PHC_CB_GO]            = cable_short;
			rd_val[8:0]                  = cable_count;
		end else if (hit_combined) begin
			rd_val[PHC_CB_SHORT]         = cable_short;
			rd_val[PHC_CB_RES_LO +: 2]   = cable_result;
			rd_val[PHC_CB_GO]            = cable_go;
			rd_val[PHC_CB_CTRL_LO +: 3]  = phy_ctrl;
			rd_val[8:0]                  = cable_count;
		end else if (hit_port_ctrl) begin
			rd_val = port_ctrl & PHC_PORT_CTRL_WMSK;
		end else if (hit_port_stat) begin
			rd_val[PHC_ST_POLARITY] = s_polarity;
			rd_val[PHC_ST_RX_FC]    = s_rx_fc;
			rd_val[PHC_ST_TX_FC]    = s_tx_fc;
			rd_val[PHC_ST_SPEED]    = s_speed;
			rd_val[PHC_ST_DUPLEX]   = s_duplex;
			rd_val[PHC_ST_XOVER]    = s_xover;
			rd_val[PHC_ST_AN_DONE]  = s_an_done;
			rd_val[PHC_ST_LINK]     = s_link;
			rd_val[4:0]             = s_partner;
		end
	end

	// read data is latched in the setup cycle so the access phase is one cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_o <= {16'h0000, rd_val};
		end
	end

	assign pready_o  = 1'b1;
	assign pslverr_o = 1'b0;
endmodule : phc_regs

// >>> verification/phc_regs_checker.sv
// assertions on the phy port register bank ports
// assumes bind to phc_regs, one clock domain
`timescale 1ns/100ps
module phc_regs_checker (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        nrst_i,
	// apb
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] pwdata_i,
	// cable tester
	input wire logic        cable_done_i,
	input wire logic        cable_test_run_o,
	// phy controls
	input wire logic        force_link_o,
	input wire logic        power_save_dis_o,
	input wire logic        near_loopback_o,
	input wire logic        tx_disable_o,
	input wire logic        an_restart_o,
	input wire logic        power_down_o,
	input wire logic        auto_mdix_dis_o,
	input wire logic        force_mdix_o,
	input wire logic        an_enable_o,
	input wire logic        force_speed_100_o,
	input wire logic        force_duplex_apply_o,
	input wire logic [4:0]  advertise_o,
	// leds
	input wire logic [3:0]  led_i,
	input wire logic [3:0]  port_led_out_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic wr;
	assign wr = psel_i && penable_i && pwrite_i;
	sequence s_idle_run;
		cable_test_run_o && !cable_done_i ##1 cable_test_run_o && !cable_done_i;
	endsequence
	sequence s_pulse;
		an_restart_o ##1 !an_restart_o;
	endsequence
	AST_RUN_START: assert property ($rose(cable_test_run_o) |-> $past(wr && pwdata_i[12], 2))
		else $error("cable run without a start write");
	AST_RUN_HOLD: assert property (s_idle_run |=> cable_test_run_o)
		else $error("cable run dropped before done");
	AST_RUN_END: assert property ($fell(cable_test_run_o) |-> $past(cable_done_i, 2))
		else $error("cable run ended without done");
	AST_AN_RESTART: assert property (an_restart_o |-> $past(wr && pwdata_i[13]) ##0 s_pulse)
		else $error("restart pulse wrong");
	AST_LED_OFF: assert property (port_led_out_o == 4'hF || port_led_out_o == $past(led_i))
		else $error("led output neither off nor led drive");
	AST_FORCE_MDIX: assert property (force_mdix_o |-> $past(auto_mdix_dis_o))
		else $error("mdi-x forced while auto crossover on");
	AST_SPEED: assert property (force_speed_100_o |-> $past(!an_enable_o))
		else $error("speed forced while negotiation on");
	AST_DUPLEX: assert property ($past(!an_enable_o) |-> force_duplex_apply_o)
		else $error("duplex not applied with negotiation off");
	AST_PHY_CTRL: assert property (!$stable({force_link_o, power_save_dis_o, near_loopback_o})
		|-> $past(wr))
		else $error("phy control changed without a write");
	AST_PORT_CTRL: assert property (!$stable({tx_disable_o, power_down_o, auto_mdix_dis_o,
		an_enable_o, advertise_o}) |-> $past(wr))
		else $error("port control changed without a write");
endmodule : phc_regs_checker

bind phc_regs phc_regs_checker u_chk (
	.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .cable_done_i(cable_done_i),
	.cable_test_run_o(cable_test_run_o), .force_link_o(force_link_o),
	.power_save_dis_o(power_save_dis_o), .near_loopback_o(near_loopback_o),
	.tx_disable_o(tx_disable_o), .an_restart_o(an_restart_o), .power_down_o(power_down_o),
	.auto_mdix_dis_o(auto_mdix_dis_o), .force_mdix_o(force_mdix_o), .an_enable_o(an_enable_o),
	.force_speed_100_o(force_speed_100_o), .force_duplex_apply_o(force_duplex_apply_o),
	.advertise_o(advertise_o), .led_i(led_i), .port_led_out_o(port_led_out_o)
);

// >>> verification/tb_phc_regs.sv
// self-checking bench for the phy port register bank
// assumes apb with pready, random stimulus from a bench lfsr
`timescale 1ns/100ps
module tb_phc_regs
	import phc_pkg::*;
;
	logic        clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, led, ledo;
	logic        pol, xov, link, andn, anf, spd, dup, rxfc, txfc, done, sh, run;
	logic        flink, psd, lb, txd, anr, pdn, mdxd, fmdx, anen, f100, ffull, fapp;
	logic [4:0]  partner, adv;
	logic [1:0]  res;
	logic [8:0]  cnt;
	logic [15:0] rnd, v;
	logic [2:0]  c;
	int          errors, num_checks, n;
	phc_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.polarity_reversed_i(pol), .crossover_state_i(xov), .link_good_i(link),
		.an_done_i(andn), .an_failed_i(anf), .op_speed_100_i(spd), .op_duplex_full_i(dup),
		.partner_ability_i(partner), .rx_flow_ctrl_i(rxfc), .tx_flow_ctrl_i(txfc),
		.cable_done_i(done), .cable_result_i(res), .short_within_ten_metres_i(sh),
		.cable_fault_count_i(cnt), .cable_test_run_o(run), .force_link_o(flink),
		.power_save_dis_o(psd), .near_loopback_o(lb), .tx_disable_o(txd), .an_restart_o(anr),
		.power_down_o(pdn), .auto_mdix_dis_o(mdxd), .force_mdix_o(fmdx), .an_enable_o(anen),
		.force_speed_100_o(f100), .force_duplex_full_o(ffull), .force_duplex_apply_o(fapp),
		.advertise_o(adv), .led_i(led), .port_led_out_o(ledo));
	// ----
	// bench helpers
	// ----
	function logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function logic [31:0] exp_status();
		return {18'h0, pol, rxfc, txfc, spd, dup, 1'b0, xov, andn, link, partner};
	endfunction : exp_status
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask : xfer
	task close_out();
		if (errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		close_out();
	end
	initial begin
		{nrst_i, psel, penable, pwrite, paddr, pwdata, led, done, res, sh, cnt} = '0;
		{pol, xov, link, andn, anf, spd, dup, rxfc, txfc, partner} = '0;
		pstrb = 4'hF;
		rnd = 16'h0038;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		xfer(1, 8'h38, 32'h31);
		xfer(0, 8'h08, 0); chk("port ctrl reset", rd, 32'h009F);
		xfer(0, 8'h00, 0); chk("combined reset", rd, 32'h0400);
		xfer(0, 8'h38, 0); chk("bank select", rd, 32'h31);
		rnd = lfsr(rnd);
		{pol, xov, link, andn, spd, dup, rxfc, txfc, partner} <= rnd[12:0];
		repeat (4) @(posedge clk_i);
		xfer(0, 8'h10, 0); chk("port status", rd, exp_status());
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			c = rnd[11:9];
			xfer(1, 8'h00, {16'h0, rnd & 16'hEFFF});
			xfer(1, 8'h38, 32'h2F);
			xfer(0, 8'h08, 0); chk("special", rd, {26'h0, pol, xov, c, 1'b0});
			chk("phy ctrl out", {flink, psd, lb}, c);
			rnd = lfsr(rnd);
			xfer(1, 8'h08, {16'h0, rnd});
			xfer(1, 8'h38, 32'h31);
			xfer(0, 8'h00, 0); chk("combined", rd, {20'h0, rnd[3:1], 9'h0});
		end
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : rnd;
			led <= rnd[3:0];
			anf <= rnd[8];
			xfer(1, 8'h08, {16'h0, v});
			@(negedge clk_i);
			chk("restart", anr, v[13]);
			@(negedge clk_i);
			chk("ctrl out", {txd, pdn, mdxd, anen, ffull, adv}, {v[14], v[11:10], v[7], v[5:0]});
			chk("forced", {fmdx, f100, fapp}, {v[10] & v[9], !v[7] & v[6], !v[7] | anf});
			chk("led", ledo, v[15] ? 4'hF : led);
			xfer(0, 8'h08, 0); chk("port ctrl", rd & 32'hDFFF, v & 16'hCEFF);
		end
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			res <= k[1:0]; cnt <= rnd[8:0]; sh <= rnd[9];
			xfer(1, 8'h00, 32'h1000);
			n = 0;
			while (run !== 1'b1 && n < 10) begin @(negedge clk_i); n++; end
			xfer(1, 8'h00, 32'h0);
			xfer(0, 8'h00, 0); chk("go held", {run, rd[12]}, 2'b11);
			done <= 1'b1;
			n = 0;
			while (run !== 1'b0 && n < 10) begin @(negedge clk_i); n++; end
			chk("run end", run, 1'b0);
			done <= 1'b0;
			repeat (2) @(posedge clk_i);
			xfer(0, 8'h00, 0); chk("result", rd, {rnd[9], k[1:0], 4'h0, rnd[8:0]});
			xfer(1, 8'h38, 32'h2F);
			xfer(0, 8'h00, 0); chk("alias", rd, {k[1:0], rnd[9], 3'h0, rnd[8:0]});
			xfer(1, 8'h38, 32'h31);
		end
		xfer(1, 8'h38, 32'h30);
		xfer(1, 8'h08, 32'hFFFF);
		xfer(0, 8'h08, 0); chk("empty bank", rd, 0);
		xfer(0, 8'h38, 0); chk("bank select 48", rd, 32'h30);
		xfer(0, 8'h3C, 0); chk("unmapped", rd, 0);
		chk("slave error", pslverr, 1'b0);
		xfer(1, 8'h38, 32'h31);
		xfer(0, 8'h08, 0); chk("port ctrl kept", rd & 32'hDFFF, v & 16'hCEFF);
		close_out();
	end
endmodule : tb_phc_regs
